/* File: core/semaphore_pkg.sv */
package semaphore_pkg;

  // ********************************************************************
  // Sizes
  // ********************************************************************
  localparam int NUM_SEMS  = 6;
  localparam int NUM_PORTS = 2;
  localparam int ADDR_W    = 3;
  localparam int DATA_W    = 8;

  // ********************************************************************
  // Field layout of a semaphore register
  // ********************************************************************
  localparam int FLAG_BIT  = 7;
  localparam int OWNER_BIT = 6;

  // ********************************************************************
  // Port numbering and owner encoding
  // ********************************************************************
  localparam int       PORT_LOCAL  = 0;
  localparam int       PORT_SYS    = 1;
  localparam logic     OWNER_LOCAL = 1'b0;
  localparam logic     OWNER_SYS   = 1'b1;

  // ********************************************************************
  // Reset state: every flag set, owned by the local controller, except
  // semaphore number two (index one), owned by the system processor.
  // ********************************************************************
  localparam logic               FLAG_AT_RESET = 1'b1;
  localparam logic [ADDR_W-1:0]  SYS_OWNED_SEM = 3'h1;
  localparam logic [DATA_W-1:0]  UNMAPPED_DATA = 8'h00;

  // ********************************************************************
  // Carriers
  // ********************************************************************
  typedef struct packed {
    logic              strobe;
    logic              write;
    logic [ADDR_W-1:0] addr;
  } bus_pins_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic              data_oe_n;
    logic              done;
  } bus_answer_t;

  typedef struct packed {
    logic flag;
    logic owner;
  } sem_state_t;

endpackage

/* File: core/semaphore_cell.sv */
`timescale 1ns/100ps

module semaphore_cell #(
  parameter logic OWNER_AT_RESET = semaphore_pkg::OWNER_LOCAL
) (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic [semaphore_pkg::NUM_PORTS-1:0] rd,
  input  wire logic [semaphore_pkg::NUM_PORTS-1:0] wr,
  output logic [semaphore_pkg::NUM_PORTS-1:0]
               [semaphore_pkg::DATA_W-1:0]   rdata
);

  semaphore_pkg::sem_state_t st;
  semaphore_pkg::sem_state_t next_st;

  // ********************************************************************
  // Read data shows the state before this cycle's access, except a system read that loses a race.
  // ********************************************************************
  always_comb begin
    rdata = '0;
    for (int p = 0; p < semaphore_pkg::NUM_PORTS; p++) begin
      rdata[p][semaphore_pkg::FLAG_BIT]  = st.flag;
      rdata[p][semaphore_pkg::OWNER_BIT] =
        (st.owner == p[0]);
    end
    // Both ports test a clear flag together: the local port wins and the
    // system port sees a set flag owned by the other side.
    if (!st.flag && rd[semaphore_pkg::PORT_LOCAL] &&
        rd[semaphore_pkg::PORT_SYS]) begin
      rdata[semaphore_pkg::PORT_SYS][semaphore_pkg::FLAG_BIT]  = 1'b1;
      rdata[semaphore_pkg::PORT_SYS][semaphore_pkg::OWNER_BIT] = 1'b0;
    end
  end

  // ********************************************************************
  // Test-and-set with fixed arbitration; a write always clears.
  // ********************************************************************
  always_comb begin
    next_st = st;
    if (|wr) begin
      next_st.flag = 1'b0;
    end else if (!st.flag && rd[semaphore_pkg::PORT_LOCAL]) begin
      next_st.flag  = 1'b1;
      next_st.owner = semaphore_pkg::OWNER_LOCAL;
    end else if (!st.flag && rd[semaphore_pkg::PORT_SYS]) begin
      next_st.flag  = 1'b1;
      next_st.owner = semaphore_pkg::OWNER_SYS;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st.flag  <= semaphore_pkg::FLAG_AT_RESET;
      st.owner <= OWNER_AT_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule

/* File: core/dual_bus_semaphore_mailbox.sv */
`timescale 1ns/100ps

// Behaviour
// - Reading a clear flag returns 0 and sets it, reading a set flag returns 1, any write clears it.
// - A sender signals ready data by writing the agreed semaphore, and the receiver treats a clear flag as its cue.
// - Each semaphore has a read-only owner flag that writes never change.
// - The owner flag names the port that set the flag, and keeps naming it after the flag is cleared.
// - The owner flag reads 1 to the port that set the flag and 0 to the other port.
// - Reset sets every flag owned by the local controller, except semaphore two owned by the system side.
// - Each register holds the flag in bit 7, the owner in bit 6, and zeros below.
// - Flags are atomic test-and-set with hardware arbitration of simultaneous accesses.
// - Six independent semaphores are reachable from both the local and the system bus.
module dual_bus_semaphore_mailbox (
  input  wire logic                       mclk,
  input  wire logic                       reset,
  input  wire semaphore_pkg::bus_pins_t   local_peripheral_controller,
  input  wire semaphore_pkg::bus_pins_t   sys_bus,
  output semaphore_pkg::bus_answer_t      local_answer,
  output semaphore_pkg::bus_answer_t      sys_answer
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    semaphore_pkg::bus_pins_t   sync1;
    semaphore_pkg::bus_pins_t   sync2;
    logic                       strobe_q;
    semaphore_pkg::bus_answer_t answer;
  } port_state_t;

  typedef struct packed {
    port_state_t [semaphore_pkg::NUM_PORTS-1:0] port;
  } main_state_t;

  main_state_t st;
  main_state_t next_st;

  semaphore_pkg::bus_pins_t [semaphore_pkg::NUM_PORTS-1:0] pins;
  logic [semaphore_pkg::NUM_PORTS-1:0]                     start;
  logic [semaphore_pkg::NUM_SEMS-1:0][semaphore_pkg::NUM_PORTS-1:0]
                                                           sem_rd;
  logic [semaphore_pkg::NUM_SEMS-1:0][semaphore_pkg::NUM_PORTS-1:0]
                                                           sem_wr;
  logic [semaphore_pkg::NUM_SEMS-1:0][semaphore_pkg::NUM_PORTS-1:0]
        [semaphore_pkg::DATA_W-1:0]                        sem_rdata;

  assign pins[semaphore_pkg::PORT_LOCAL] = local_peripheral_controller;
  assign pins[semaphore_pkg::PORT_SYS]   = sys_bus;

  // ********************************************************************
  // Access decode
  // ********************************************************************
  // Each bus runs in its own timing, so an access counts once, on the
  // rising edge of its synchronised strobe.
  always_comb begin
    start  = '0;
    sem_rd = '0;
    sem_wr = '0;
    for (int p = 0; p < semaphore_pkg::NUM_PORTS; p++) begin
      start[p] = st.port[p].sync2.strobe && !st.port[p].strobe_q;
      for (int s = 0; s < semaphore_pkg::NUM_SEMS; s++) begin
        if (start[p] &&
            st.port[p].sync2.addr == s[semaphore_pkg::ADDR_W-1:0]) begin
          sem_wr[s][p] = st.port[p].sync2.write;
          sem_rd[s][p] = !st.port[p].sync2.write;
        end
      end
    end
  end

  // ********************************************************************
  // Semaphores
  // ********************************************************************
  for (genvar s = 0; s < semaphore_pkg::NUM_SEMS; s++) begin : g_sem
    semaphore_cell #(
      .OWNER_AT_RESET((s == int'(semaphore_pkg::SYS_OWNED_SEM)) ?
                      semaphore_pkg::OWNER_SYS :
                      semaphore_pkg::OWNER_LOCAL)
    ) u_cell (
      .mclk  (mclk),
      .reset (reset),
      .rd    (sem_rd[s]),
      .wr    (sem_wr[s]),
      .rdata (sem_rdata[s])
    );
  end

  // ********************************************************************
  // Port front ends
  // ********************************************************************
  always_comb begin
    next_st = st;
    for (int p = 0; p < semaphore_pkg::NUM_PORTS; p++) begin
      next_st.port[p].sync1         = pins[p];
      next_st.port[p].sync2         = st.port[p].sync1;
      next_st.port[p].strobe_q      = st.port[p].sync2.strobe;
      next_st.port[p].answer.done   = 1'b0;
      if (!st.port[p].sync2.strobe) begin
        next_st.port[p].answer.data_oe_n = 1'b1;
      end
      if (start[p]) begin
        next_st.port[p].answer.done = 1'b1;
        if (!st.port[p].sync2.write) begin
          // Unmapped addresses read as zero; writes there are ignored.
          next_st.port[p].answer.rdata     = semaphore_pkg::UNMAPPED_DATA;
          next_st.port[p].answer.data_oe_n = 1'b0;
          for (int s = 0; s < semaphore_pkg::NUM_SEMS; s++) begin
            if (st.port[p].sync2.addr == s[semaphore_pkg::ADDR_W-1:0]) begin
              next_st.port[p].answer.rdata = sem_rdata[s][p];
            end
          end
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      for (int p = 0; p < semaphore_pkg::NUM_PORTS; p++) begin
        st.port[p].sync1            <= '0;
        st.port[p].sync2            <= '0;
        st.port[p].strobe_q         <= 1'b0;
        st.port[p].answer.rdata     <= semaphore_pkg::UNMAPPED_DATA;
        st.port[p].answer.data_oe_n <= 1'b1;
        st.port[p].answer.done      <= 1'b0;
      end
    end else begin
      st <= next_st;
    end
  end

  assign local_answer = st.port[semaphore_pkg::PORT_LOCAL].answer;
  assign sys_answer   = st.port[semaphore_pkg::PORT_SYS].answer;

endmodule

/* File: tb/sem_checker.sv */
`timescale 1ns/100ps
module sem_checker (
  input wire logic                       mclk,
  input wire logic                       reset,
  input wire semaphore_pkg::bus_pins_t   local_peripheral_controller,
  input wire semaphore_pkg::bus_pins_t   sys_bus,
  input wire semaphore_pkg::bus_answer_t local_answer,
  input wire semaphore_pkg::bus_answer_t sys_answer
);
  // ********************************************************************
  // Port timing and read data checks.
  // ********************************************************************
  wire semaphore_pkg::bus_pins_t   l  = local_peripheral_controller;
  wire semaphore_pkg::bus_pins_t   s  = sys_bus;
  wire semaphore_pkg::bus_answer_t la = local_answer;
  wire semaphore_pkg::bus_answer_t sa = sys_answer;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  property p_l_lat; $rose(l.strobe) |-> ##3 la.done; endproperty
  property p_s_lat; $rose(s.strobe) |-> ##3 sa.done; endproperty
  property p_l_zero; la.rdata[5:0] == 6'h00; endproperty
  property p_s_zero; sa.rdata[5:0] == 6'h00; endproperty
  property p_pulse; la.done |=> !la.done; endproperty
  sequence s_race;
    $rose(l.strobe) && $rose(s.strobe) && !l.write && !s.write &&
    l.addr == s.addr && l.addr < 3'h6;
  endsequence
  property p_race; s_race |-> ##3 (la.rdata[7] || sa.rdata[7]); endproperty
  property p_unmap;
    $rose(l.strobe) && !l.write && l.addr > 3'h5 |-> ##3 la.rdata == 8'h00;
  endproperty
  property p_oe; $rose(s.strobe) && !s.write |-> ##3 !sa.data_oe_n;
  endproperty
  a_l_lat: assert property (p_l_lat) else $error("local answer late");
  a_s_lat: assert property (p_s_lat) else $error("sys answer late");
  a_l_zero: assert property (p_l_zero) else $error("local low bits");
  a_s_zero: assert property (p_s_zero) else $error("sys low bits");
  a_pulse: assert property (p_pulse) else $error("done too long");
  a_race: assert property (p_race) else $error("both ports won");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  a_oe: assert property (p_oe) else $error("sys data not driven");
  c_race: cover property (s_race);
  c_unmap: cover property ($rose(l.strobe) && l.addr > 3'h5);
  c_clear: cover property (sa.done && !sa.data_oe_n && !sa.rdata[7]);
endmodule
bind dual_bus_semaphore_mailbox sem_checker i_chk (
  .mclk                        (mclk),
  .reset                       (reset),
  .local_peripheral_controller (local_peripheral_controller),
  .sys_bus                     (sys_bus),
  .local_answer                (local_answer),
  .sys_answer                  (sys_answer)
);

/* File: tb/sys_cpu_model.sv */
`timescale 1ns/100ps
module sys_cpu_model (
  input  wire logic                       mclk,
  input  wire semaphore_pkg::bus_answer_t ans,
  output semaphore_pkg::bus_pins_t        pins
);
  // ********************************************************************
  // System processor: single accesses and the polling loop.
  // ********************************************************************
  logic [7:0] rd;
  initial pins = '0;
  task acc(input logic w, input logic [2:0] a, output bit ok);
    int n;
    begin
      @(posedge mclk);
      pins <= '{strobe: 1'b1, write: w, addr: a};
      n = 0;
      do begin @(negedge mclk); n++; end while (ans.done !== 1'b1 && n < 20);
      rd = ans.rdata;
      ok = n < 20;
      @(posedge mclk);
      pins <= '{strobe: 1'b0, write: ~w, addr: ~a};
      repeat (3) @(posedge mclk);
    end
  endtask
  task poll(input logic [2:0] a, input int lim, output int n);
    bit ok;
    begin
      n = 0;
      do begin acc(1'b0, a, ok); n++; end
      while (ok && (rd & 8'h80) != 8'h00 && n < lim);
      // A lost answer is reported as an impossible count.
      if (!ok) n = -1;
    end
  endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/100ps
module tb;
  // ********************************************************************
  // Stimulus, reference state and scoreboard.
  // ********************************************************************
  logic                       mclk = 1'b0;
  logic                       reset = 1'b1;
  semaphore_pkg::bus_pins_t   lp = '0;
  semaphore_pkg::bus_pins_t   sp;
  semaphore_pkg::bus_answer_t la;
  semaphore_pkg::bus_answer_t sa;
  logic [5:0]                 flg = '1;
  logic [5:0]                 own = 6'h02;
  logic [7:0]                 q[2][$];
  int                         error_cnt = 0;
  int                         n_compared = 0;
  int                         seed = 40508;
  int                         n;
  bit                         ok;
  always #20 mclk = ~mclk;
  dual_bus_semaphore_mailbox i_dut (.mclk(mclk), .reset(reset),
    .local_peripheral_controller(lp), .sys_bus(sp),
    .local_answer(la), .sys_answer(sa));
  sys_cpu_model i_sys (.mclk(mclk), .ans(sa), .pins(sp));
  task end_sim;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task note(input int p, input logic [2:0] a);
    logic [7:0] e;
    begin
      e = 8'h00;
      if (a < 3'h6) begin
        e = {flg[a], own[a] == p[0], 6'h00};
        if (!flg[a]) own[a] = p[0];
        flg[a] = 1'b1;
      end
      q[p].push_back(e);
    end
  endtask
  task chk(input int p, input semaphore_pkg::bus_answer_t x);
    logic [7:0] e;
    begin
      if (x.done === 1'b1 && x.data_oe_n === 1'b0) begin
        e = q[p].size() > 0 ? q[p].pop_front() : 8'hxx;
        n_compared++;
        if (x.rdata !== e) begin
          error_cnt++;
          $display("CHECK FAILED rdata %0d expected %h seen %h", p, e, x.rdata);
        end
      end
    end
  endtask
  always @(negedge mclk) begin
    chk(0, la);
    chk(1, sa);
  end
  task lacc(input logic w, input logic [2:0] a);
    int k;
    begin
      @(posedge mclk);
      lp <= '{strobe: 1'b1, write: w, addr: a};
      k = 0;
      do begin @(negedge mclk); k++; end while (la.done !== 1'b1 && k < 20);
      if (k >= 20) begin error_cnt++; end_sim(); end
      @(posedge mclk);
      lp <= '{strobe: 1'b0, write: ~w, addr: ~a};
      repeat (3) @(posedge mclk);
    end
  endtask
  task op(input int p, input logic w, input logic [2:0] a);
    if (!w) note(p, a);
    else if (a < 3'h6) flg[a] = 1'b0;
    if (p == 0) lacc(w, a);
    else begin
      i_sys.acc(w, a, ok);
      if (!ok) begin error_cnt++; end_sim(); end
    end
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 16; i++) op(i / 8, 1'b0, 3'(i));
    op(1, 1'b0, 3'h0);
    op(0, 1'b1, 3'h0);
    repeat (8) @(posedge mclk);
    note(1, 3'h0);
    i_sys.poll(3'h0, 4, n);
    n_compared++;
    if (n != 1) begin
      error_cnt++;
      $display("CHECK FAILED poll count expected 1 seen %0d", n);
    end
    op(0, 1'b0, 3'h0);
    op(0, 1'b1, 3'h3);
    note(0, 3'h3);
    note(1, 3'h3);
    fork
      lacc(1'b0, 3'h3);
      i_sys.acc(1'b0, 3'h3, ok);
    join
    if (!ok) begin error_cnt++; end_sim(); end
    repeat (40) op($random(seed) & 1, 1'($random(seed)), 3'($random(seed)));
    repeat (5) @(posedge mclk);
    end_sim();
  end
endmodule
